// [shared/mpr_pkg.sv]
/*
  Shared constants for the mode-register-3 and calibration readout block.
  Assumes an x8 data path and a command bus sampled on the link clock.
*/
`default_nettype none

package mpr_pkg;

  // ---------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------
  localparam int MODE_W    = 19;
  localparam int ADDR_W    = 14;
  localparam int BANK_W    = 3;
  localparam int DQ_W      = 8;
  localparam int LAT_W     = 5;
  localparam int LAT_DEPTH = 32;

  // ---------------------------------------------------------------
  // mode register 3 field layout and reset value
  // ---------------------------------------------------------------
  localparam int MPR_EN_BIT  = 2;
  localparam int MPR_SEL_LO  = 0;
  localparam int MPR_SEL_HI  = 1;
  localparam int MODE_BA_LO  = 16;
  localparam int MODE_BA_HI  = 18;
  localparam logic [MODE_W-1:0] MODE_RESET = 19'h00000;

  localparam logic [1:0]        SEL_CAL_PATTERN = 2'h0;
  localparam logic [BANK_W-1:0] BANK_SEL_MR3    = 3'h3;

  // bit 0 is beat 0, bit 7 is beat 7: 0,1,0,1,0,1,0,1
  localparam logic [7:0] CAL_PATTERN = 8'haa;

  // ---------------------------------------------------------------
  // burst and latency counts
  // ---------------------------------------------------------------
  localparam logic [3:0] BEATS_BL8 = 4'h8;
  localparam logic [3:0] BEATS_BC4 = 4'h4;
  localparam logic [2:0] BEAT_UPPER_START = 3'h4;
  localparam int ADDR_RDAP_BIT = 10;
  localparam int ADDR_A2_BIT   = 2;
  localparam int ADDR_OTF_BIT  = 12;
  // stages spent in pin sync, decode and output registers
  localparam logic [5:0] LAUNCH_OFFSET = 6'h03;

  // ---------------------------------------------------------------
  // command encodings {cs_n, ras_n, cas_n, we_n}
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    CMD_MODE_SET = 4'b0000,
    CMD_READ     = 4'b0101,
    CMD_WRITE    = 4'b0100
  } mpr_cmd_type;

  typedef enum logic [0:0] {
    BURST_IDLE   = 1'b0,
    BURST_ACTIVE = 1'b1
  } mpr_burst_type;

endpackage

`default_nettype wire

// [hdl/mpr_word_crossing.sv]
/*
  Toggle handshake that carries a mode word from the link clock to the core clock.
  Assumes the source holds off a new word for longer than the sync delay.
*/
`timescale 1ns/1ps
`default_nettype none

module mpr_word_crossing
(
  // source side
  input  wire logic                     src_clk,
  input  wire logic                     src_rst,
  input  wire logic                     src_load,
  input  wire logic [mpr_pkg::MODE_W-1:0] src_word,
  // destination side
  input  wire logic                     dst_clk,
  input  wire logic                     dst_rst,
  output var  logic [mpr_pkg::MODE_W-1:0] dst_word,
  output var  logic                     dst_strobe
);

  logic [mpr_pkg::MODE_W-1:0] hold_reg;
  logic                       toggle_reg;
  logic                       tog_s1_reg;
  logic                       tog_s2_reg;
  logic                       tog_s3_reg;

  always_ff @(posedge src_clk or posedge src_rst)
  begin
    if (src_rst)
    begin
      hold_reg   <= mpr_pkg::MODE_RESET;
      toggle_reg <= 1'b0;
    end
    else if (src_load)
    begin
      hold_reg   <= src_word;
      toggle_reg <= ~toggle_reg;
    end
  end

  always_ff @(posedge dst_clk or posedge dst_rst)
  begin
    if (dst_rst)
    begin
      tog_s1_reg <= 1'b0;
      tog_s2_reg <= 1'b0;
      tog_s3_reg <= 1'b0;
    end
    else
    begin
      tog_s1_reg <= toggle_reg;
      tog_s2_reg <= tog_s1_reg;
      tog_s3_reg <= tog_s2_reg;
    end
  end

  // hold_reg is stable by the time the toggle edge is seen
  always_ff @(posedge dst_clk or posedge dst_rst)
  begin
    if (dst_rst)
    begin
      dst_word   <= mpr_pkg::MODE_RESET;
      dst_strobe <= 1'b0;
    end
    else
    begin
      dst_strobe <= tog_s2_reg ^ tog_s3_reg;
      if (tog_s2_reg ^ tog_s3_reg)
      begin
        dst_word <= hold_reg;
      end
    end
  end

endmodule // mpr_word_crossing

`default_nettype wire

// [hdl/mpr_calibration_readout.sv]
/*
  Mode register 3 and the calibration-pattern readout path of a DRAM device.
  Assumes command pins and configuration levels arrive with the link clock,
  one data beat per link clock, and an array model that answers beat requests
  combinationally in the same link cycle.
*/
`timescale 1ns/1ps
`default_nettype none

module mpr_calibration_readout
(
  // core clock and reset
  input  wire logic                          CORE_CLK,
  input  wire logic                          SYS_RST,
  // link clock
  input  wire logic                          LINK_CK,
  // command pins
  input  wire logic                          CS_N,
  input  wire logic                          RAS_N,
  input  wire logic                          CAS_N,
  input  wire logic                          WE_N,
  input  wire logic [mpr_pkg::BANK_W-1:0]    BANK_ADDR,
  input  wire logic [mpr_pkg::ADDR_W-1:0]    ADDR,
  // data pins
  input  wire logic [mpr_pkg::DQ_W-1:0]      DQ_IN,
  output var  logic [mpr_pkg::DQ_W-1:0]      DQ_OUT,
  output var  logic                          DQ_OE_N,
  // settings from other mode registers, link clock domain
  input  wire logic [mpr_pkg::LAT_W-1:0]     ADDITIVE_LATENCY,
  input  wire logic [mpr_pkg::LAT_W-1:0]     CAS_LATENCY,
  input  wire logic                          BURST_OTF_EN,
  input  wire logic                          BURST_FIXED_CHOP,
  input  wire logic                          DLL_LOCKED,
  input  wire logic                          MPR_ALL_DQ,
  // array side, link clock domain
  output var  logic                          ARRAY_RD_REQ,
  output var  logic                          ARRAY_WR_REQ,
  output var  logic [mpr_pkg::ADDR_W-1:0]    ARRAY_COL_ADDR,
  output var  logic [mpr_pkg::BANK_W-1:0]    ARRAY_BANK,
  output logic                               ARRAY_BEAT_REQ,
  output var  logic [2:0]                    ARRAY_BEAT_INDEX,
  input  wire logic [mpr_pkg::DQ_W-1:0]      ARRAY_RD_DATA,
  output var  logic [mpr_pkg::DQ_W-1:0]      ARRAY_WR_DATA,
  // status, core clock domain
  output var  logic                          MPR_ENABLED,
  output var  logic [mpr_pkg::MODE_W-1:0]    MODE_WORD,
  output var  logic                          MODE_UPDATED
);

  // ---------------------------------------------------------------
  // functions
  // ---------------------------------------------------------------
  function automatic logic [5:0] launch_tap(input logic [mpr_pkg::LAT_W-1:0] al,
                                            input logic [mpr_pkg::LAT_W-1:0] cl);
    logic [5:0] rl;
    rl = {1'b0, al} + {1'b0, cl};
    // latencies below the pipeline depth are clamped to the shortest path
    if (rl < mpr_pkg::LAUNCH_OFFSET)
      launch_tap = 6'h00;
    else
      launch_tap = rl - mpr_pkg::LAUNCH_OFFSET;
  endfunction

  function automatic logic [mpr_pkg::DQ_W-1:0] spread_bit(input logic b, input logic all_dq);
    if (all_dq)
      spread_bit = {mpr_pkg::DQ_W{b}};
    else
      spread_bit = {{(mpr_pkg::DQ_W-1){1'b0}}, b};
  endfunction

  // ---------------------------------------------------------------
  // link reset: asserts at once, releases on the link clock
  // ---------------------------------------------------------------
  logic link_rst_s1_reg;
  logic link_rst_reg;

  always_ff @(posedge LINK_CK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      link_rst_s1_reg <= 1'b1;
      link_rst_reg    <= 1'b1;
    end
    else
    begin
      link_rst_s1_reg <= 1'b0;
      link_rst_reg    <= link_rst_s1_reg;
    end
  end

  // ---------------------------------------------------------------
  // pin capture, two stages
  // ---------------------------------------------------------------
  logic [3:0]                  cmd_s1_reg;
  logic [3:0]                  cmd_s2_reg;
  logic [mpr_pkg::BANK_W-1:0]  ba_s1_reg;
  logic [mpr_pkg::BANK_W-1:0]  ba_s2_reg;
  logic [mpr_pkg::ADDR_W-1:0]  addr_s1_reg;
  logic [mpr_pkg::ADDR_W-1:0]  addr_s2_reg;
  logic [mpr_pkg::DQ_W-1:0]    dq_s1_reg;
  logic [mpr_pkg::DQ_W-1:0]    dq_s2_reg;

  always_ff @(posedge LINK_CK or posedge link_rst_reg)
  begin
    if (link_rst_reg)
    begin
      cmd_s1_reg  <= 4'hf;
      cmd_s2_reg  <= 4'hf;
      ba_s1_reg   <= 3'h0;
      ba_s2_reg   <= 3'h0;
      addr_s1_reg <= 14'h0000;
      addr_s2_reg <= 14'h0000;
      dq_s1_reg   <= 8'h00;
      dq_s2_reg   <= 8'h00;
    end
    else
    begin
      cmd_s1_reg  <= {CS_N, RAS_N, CAS_N, WE_N};
      cmd_s2_reg  <= cmd_s1_reg;
      ba_s1_reg   <= BANK_ADDR;
      ba_s2_reg   <= ba_s1_reg;
      addr_s1_reg <= ADDR;
      addr_s2_reg <= addr_s1_reg;
      dq_s1_reg   <= DQ_IN;
      dq_s2_reg   <= dq_s1_reg;
    end
  end

  // ---------------------------------------------------------------
  // command decode
  // ---------------------------------------------------------------
  logic is_mode_set;
  logic is_read;
  logic is_write;
  logic mr3_load;

  assign is_mode_set = (cmd_s2_reg == mpr_pkg::CMD_MODE_SET);
  assign is_read     = (cmd_s2_reg == mpr_pkg::CMD_READ);   // RDAP differs only in bit 10
  assign is_write    = (cmd_s2_reg == mpr_pkg::CMD_WRITE);
  assign mr3_load    = is_mode_set && (ba_s2_reg == mpr_pkg::BANK_SEL_MR3);

  // ---------------------------------------------------------------
  // calibration_pattern_mode register
  // ---------------------------------------------------------------
  logic [mpr_pkg::MODE_W-1:0] calibration_pattern_mode_reg;
  logic [mpr_pkg::MODE_W-1:0] calibration_pattern_mode_next;
  logic                       mpr_on;
  logic [1:0]                 mpr_sel;

  always_comb
  begin
    calibration_pattern_mode_next = mpr_pkg::MODE_RESET;
    calibration_pattern_mode_next[mpr_pkg::MODE_BA_HI:mpr_pkg::MODE_BA_LO] = ba_s2_reg;
    calibration_pattern_mode_next[mpr_pkg::ADDR_W-1:0] = addr_s2_reg;
  end

  // only a mode-set to this register changes it; the array is untouched
  always_ff @(posedge LINK_CK or posedge link_rst_reg)
  begin
    if (link_rst_reg)
      calibration_pattern_mode_reg <= mpr_pkg::MODE_RESET;
    else if (mr3_load)
      calibration_pattern_mode_reg <= calibration_pattern_mode_next;
  end

  assign mpr_on  = calibration_pattern_mode_reg[mpr_pkg::MPR_EN_BIT];
  // select bits only matter once readout is on
  assign mpr_sel = mpr_on ? calibration_pattern_mode_reg[mpr_pkg::MPR_SEL_HI:mpr_pkg::MPR_SEL_LO]
                          : mpr_pkg::SEL_CAL_PATTERN;

  // ---------------------------------------------------------------
  // array requests
  // ---------------------------------------------------------------
  logic rd_chop;

  // fixed chop from mode register 0 unless on-the-fly is enabled
  assign rd_chop = BURST_OTF_EN ? ~addr_s2_reg[mpr_pkg::ADDR_OTF_BIT] : BURST_FIXED_CHOP;

  always_ff @(posedge LINK_CK or posedge link_rst_reg)
  begin
    if (link_rst_reg)
    begin
      ARRAY_RD_REQ   <= 1'b0;
      ARRAY_WR_REQ   <= 1'b0;
      ARRAY_COL_ADDR <= 14'h0000;
      ARRAY_BANK     <= 3'h0;
      ARRAY_WR_DATA  <= 8'h00;
    end
    else
    begin
      // reads are diverted while readout is on; writes are dropped then
      ARRAY_RD_REQ <= is_read && !mpr_on;
      ARRAY_WR_REQ <= is_write && !mpr_on;
      if ((is_read || is_write) && !mpr_on)
      begin
        ARRAY_COL_ADDR <= addr_s2_reg;
        ARRAY_BANK     <= ba_s2_reg;
      end
      if (!mpr_on)
        ARRAY_WR_DATA <= dq_s2_reg;
    end
  end

  // ---------------------------------------------------------------
  // read latency delay line
  // ---------------------------------------------------------------
  // descriptor: {pattern read, chop, upper half}
  logic [mpr_pkg::LAT_DEPTH-1:0] lat_valid_reg;
  logic [2:0]                    lat_desc_reg [mpr_pkg::LAT_DEPTH];
  logic [5:0]                    tap;
  logic                          launch;
  logic [2:0]                    launch_desc;

  assign tap         = launch_tap(ADDITIVE_LATENCY, CAS_LATENCY);
  assign launch      = lat_valid_reg[tap[4:0]];
  assign launch_desc = lat_desc_reg[tap[4:0]];

  always_ff @(posedge LINK_CK or posedge link_rst_reg)
  begin
    if (link_rst_reg)
    begin
      lat_valid_reg <= '0;
      for (int i = 0; i < mpr_pkg::LAT_DEPTH; i++)
        lat_desc_reg[i] <= 3'h0;
    end
    else
    begin
      // no read leaves without a locked loop; bank and column bits other than a2, and a12 when on-the-fly, are ignored
      lat_valid_reg <= {lat_valid_reg[mpr_pkg::LAT_DEPTH-2:0], is_read && DLL_LOCKED};
      lat_desc_reg[0] <= {mpr_on, rd_chop, addr_s2_reg[mpr_pkg::ADDR_A2_BIT]};
      for (int i = 1; i < mpr_pkg::LAT_DEPTH; i++)
        lat_desc_reg[i] <= lat_desc_reg[i-1];
    end
  end

  // ---------------------------------------------------------------
  // burst sequencer
  // ---------------------------------------------------------------
  mpr_pkg::mpr_burst_type burst_state_reg;
  logic [3:0]             beats_left_reg;
  logic                   burst_mpr_reg;

  always_ff @(posedge LINK_CK or posedge link_rst_reg)
  begin
    if (link_rst_reg)
    begin
      burst_state_reg  <= mpr_pkg::BURST_IDLE;
      beats_left_reg   <= 4'h0;
      burst_mpr_reg    <= 1'b0;
      ARRAY_BEAT_INDEX <= 3'h0;
    end
    else if (launch)
    begin
      // a new burst cuts off any tail still running
      burst_state_reg <= mpr_pkg::BURST_ACTIVE;
      burst_mpr_reg   <= launch_desc[2];
      beats_left_reg  <= launch_desc[1] ? mpr_pkg::BEATS_BC4 : mpr_pkg::BEATS_BL8;
      // full bursts start at 0, chopped ones at 0 or 4
      if (launch_desc[1] && launch_desc[0])
        ARRAY_BEAT_INDEX <= mpr_pkg::BEAT_UPPER_START;
      else
        ARRAY_BEAT_INDEX <= 3'h0;
    end
    else
    begin
      unique case (burst_state_reg)
        mpr_pkg::BURST_IDLE:
        begin
          beats_left_reg <= 4'h0;
        end
        mpr_pkg::BURST_ACTIVE:
        begin
          ARRAY_BEAT_INDEX <= ARRAY_BEAT_INDEX + 3'h1;
          beats_left_reg   <= beats_left_reg - 4'h1;
          if (beats_left_reg == 4'h1)
            burst_state_reg <= mpr_pkg::BURST_IDLE;
        end
      endcase
    end
  end

  assign ARRAY_BEAT_REQ = (burst_state_reg == mpr_pkg::BURST_ACTIVE) && !burst_mpr_reg;

  // ---------------------------------------------------------------
  // data pins
  // ---------------------------------------------------------------
  logic pattern_bit;

  // reserved select codes read as zero
  assign pattern_bit = (mpr_sel == mpr_pkg::SEL_CAL_PATTERN) ? mpr_pkg::CAL_PATTERN[ARRAY_BEAT_INDEX]
                                                             : 1'b0;

  always_ff @(posedge LINK_CK or posedge link_rst_reg)
  begin
    if (link_rst_reg)
    begin
      DQ_OUT  <= 8'h00;
      DQ_OE_N <= 1'b1;
    end
    else if (burst_state_reg == mpr_pkg::BURST_ACTIVE)
    begin
      DQ_OE_N <= 1'b0;
      if (burst_mpr_reg)
        DQ_OUT <= spread_bit(pattern_bit, MPR_ALL_DQ);
      else
        DQ_OUT <= ARRAY_RD_DATA;
    end
    else
    begin
      DQ_OUT  <= 8'h00;
      DQ_OE_N <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // status towards the core clock
  // ---------------------------------------------------------------
  logic mpr_s1_reg;

  always_ff @(posedge CORE_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      mpr_s1_reg  <= 1'b0;
      MPR_ENABLED <= 1'b0;
    end
    else
    begin
      mpr_s1_reg  <= mpr_on;
      MPR_ENABLED <= mpr_s1_reg;
    end
  end

  // mode-sets are spaced far wider than the handshake takes
  mpr_word_crossing u_mode_crossing
  (
    .src_clk    (LINK_CK),
    .src_rst    (link_rst_reg),
    .src_load   (mr3_load),
    .src_word   (calibration_pattern_mode_next),
    .dst_clk    (CORE_CLK),
    .dst_rst    (SYS_RST),
    .dst_word   (MODE_WORD),
    .dst_strobe (MODE_UPDATED)
  );

endmodule // mpr_calibration_readout

`default_nettype wire

// [testbench/mpr_readout_assertions.sv]
/*
  Checker for the calibration readout block, bound to its top module.
  Assumes bursts are never cut short by a following read.
*/
`timescale 1ns/1ps
`default_nettype none

module mpr_readout_checker
(
  // clock and reset
  input wire logic                       LINK_CK,
  input wire logic                       SYS_RST,
  // command pins
  input wire logic                       CS_N,
  input wire logic                       RAS_N,
  input wire logic                       CAS_N,
  input wire logic                       WE_N,
  // data and settings
  input wire logic                       MPR_ALL_DQ,
  input wire logic [mpr_pkg::DQ_W-1:0]   DQ_OUT,
  input wire logic                       DQ_OE_N,
  // array and status
  input wire logic                       ARRAY_RD_REQ,
  input wire logic                       ARRAY_WR_REQ,
  input wire logic                       MPR_ENABLED,
  input wire logic [mpr_pkg::MODE_W-1:0] MODE_WORD
);
  wire [3:0] pins = {CS_N, RAS_N, CAS_N, WE_N};

  default clocking cb @(posedge LINK_CK);
  endclocking
  default disable iff (SYS_RST);

  property p_burst_len;
    $fell(DQ_OE_N) |-> ##4 (DQ_OE_N or (!DQ_OE_N [*4] ##1 DQ_OE_N));
  endproperty
  a_burst_len: assert property (p_burst_len) else $error("burst neither four nor eight beats");

  property p_first_zero;
    $fell(DQ_OE_N) && MPR_ENABLED |-> DQ_OUT == 8'h00;
  endproperty
  a_first_zero: assert property (p_first_zero) else $error("first pattern beat not zero");

  property p_prime_dq;
    !DQ_OE_N && MPR_ENABLED && !MPR_ALL_DQ |-> DQ_OUT[7:1] == 7'h00;
  endproperty
  a_prime_dq: assert property (p_prime_dq) else $error("non-prime lines not low");

  property p_alternate;
    !DQ_OE_N && !$past(DQ_OE_N) && MPR_ENABLED && MODE_WORD[1:0] == 2'h0 |-> DQ_OUT[0] != $past(DQ_OUT[0]);
  endproperty
  a_alternate: assert property (p_alternate) else $error("pattern beats do not alternate");

  property p_reserved_zero;
    !DQ_OE_N && MPR_ENABLED && MODE_WORD[1:0] != 2'h0 |-> DQ_OUT == 8'h00;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved select not zero");

  property p_mrs_no_write;
    pins == 4'h0 |-> ##3 !ARRAY_WR_REQ;
  endproperty
  a_mrs_no_write: assert property (p_mrs_no_write) else $error("mode set wrote the array");

  property p_normal_write;
    !MPR_ENABLED && pins == 4'h4 |-> ##3 ARRAY_WR_REQ;
  endproperty
  a_normal_write: assert property (p_normal_write) else $error("write did not reach array");

  property p_redirect;
    MPR_ENABLED && pins == 4'h5 |-> ##3 !ARRAY_RD_REQ;
  endproperty
  a_redirect: assert property (p_redirect) else $error("read reached array in readout mode");

  property p_normal_read;
    !MPR_ENABLED && pins == 4'h5 |-> ##3 ARRAY_RD_REQ;
  endproperty
  a_normal_read: assert property (p_normal_read) else $error("read did not reach array");
endmodule // mpr_readout_checker

bind mpr_calibration_readout mpr_readout_checker u_checker (.LINK_CK, .SYS_RST, .CS_N, .RAS_N, .CAS_N, .WE_N,
  .MPR_ALL_DQ, .DQ_OUT, .DQ_OE_N, .ARRAY_RD_REQ, .ARRAY_WR_REQ, .MPR_ENABLED, .MODE_WORD);

`default_nettype wire

// [testbench/mpr_ctrl_model.sv]
/*
  Memory controller model: drives command pins and captures data beats.
  Assumes the caller keeps banks idle around mode sets.
*/
`timescale 1ns/1ps
`default_nettype none

module mpr_ctrl_model
(
  // link clock
  input  wire logic                       link_ck,
  // command pins {cs_n, ras_n, cas_n, we_n}
  output var  logic [3:0]                 cmd,
  output var  logic [mpr_pkg::BANK_W-1:0] bank,
  output var  logic [mpr_pkg::ADDR_W-1:0] addr,
  // data pins
  input  wire logic [mpr_pkg::DQ_W-1:0]   dq,
  input  wire logic                       dq_oe_n
);
  logic [7:0] beats [$];
  int         cyc = 0;
  int         first_cyc = 0;

  initial
  begin
    cmd = 4'hf;
    bank = 3'h0;
    addr = 14'h0000;
  end

  always @(posedge link_ck)
    cyc <= cyc + 1;

  // mid-cycle capture, the registered beat has settled
  always @(negedge link_ck)
    if (dq_oe_n === 1'b0)
    begin
      if (beats.size() == 0)
        first_cyc = cyc;
      beats.push_back(dq);
    end

  // one command cycle; at is the edge that samples it
  task automatic issue(input logic [3:0] c, input logic [2:0] b, input logic [13:0] a, output int at);
    @(posedge link_ck);
    #1;
    cmd = c;
    bank = b;
    addr = a;
    at = cyc + 1;
    @(posedge link_ck);
    #1;
    cmd = 4'hf;
    // deselected: lines wander instead of holding
    bank = ~b;
    addr = ~a;
  endtask

  // called only with banks idle; long settle after
  task automatic mode_set(input logic en, input logic [1:0] sel);
    int at;
    issue(mpr_pkg::CMD_MODE_SET, mpr_pkg::BANK_SEL_MR3, {11'h000, en, sel}, at);
    repeat (20) @(posedge link_ck);
    #1;
  endtask

  // low column bits forced to zero
  task automatic read(input logic [2:0] b, input logic [13:0] a, output int at);
    beats.delete();
    issue(mpr_pkg::CMD_READ, b, {a[13:2], 2'h0}, at);
  endtask
endmodule // mpr_ctrl_model

`default_nettype wire

// [testbench/testbench.sv]
/*
  Self-checking bench for the calibration readout block.
  Assumes the controller model and the bound checker.
*/
`timescale 1ns/1ps
`default_nettype none

module testbench;
  logic CORE_CLK = 1'b0;
  logic LINK_CK = 1'b0;
  logic SYS_RST = 1'b1;
  logic [3:0] cmd;
  logic [2:0] bank, arr_bank, beat_idx;
  logic [13:0] addr, arr_col;
  logic [7:0] dq_in = 8'h00;
  logic [7:0] dq_out, arr_wdata;
  logic [4:0] al = 5'h00;
  logic [4:0] cl = 5'h05;
  logic otf = 1'b1;
  logic fix_chop = 1'b0;
  logic dll = 1'b1;
  logic all_dq = 1'b0;
  logic dq_oe_n, arr_rd, arr_wr, beat_req, mpr_en, mode_upd;
  logic [18:0] mode_word;
  logic [31:0] seed = 32'hd876;
  int errors = 0;
  int check_count = 0;
  int upd_count = 0;

  // every accepted mode-set must reach the core side exactly once
  always @(posedge CORE_CLK)
    if (mode_upd === 1'b1)
      upd_count++;

  // array stand-in, scrambled when not asked
  wire logic [7:0] arr_data = beat_req ? {5'h13, beat_idx} : ~{5'h13, beat_idx};

  always #4 CORE_CLK = ~CORE_CLK;

  initial
  begin
    #2.3;
    forever #7.5 LINK_CK = ~LINK_CK;
  end

  mpr_calibration_readout DUT
  (
    .CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST), .LINK_CK(LINK_CK), .CS_N(cmd[3]), .RAS_N(cmd[2]),
    .CAS_N(cmd[1]), .WE_N(cmd[0]), .BANK_ADDR(bank), .ADDR(addr), .DQ_IN(dq_in), .DQ_OUT(dq_out),
    .DQ_OE_N(dq_oe_n), .ADDITIVE_LATENCY(al), .CAS_LATENCY(cl), .BURST_OTF_EN(otf),
    .BURST_FIXED_CHOP(fix_chop), .DLL_LOCKED(dll), .MPR_ALL_DQ(all_dq), .ARRAY_RD_REQ(arr_rd),
    .ARRAY_WR_REQ(arr_wr), .ARRAY_COL_ADDR(arr_col), .ARRAY_BANK(arr_bank), .ARRAY_BEAT_REQ(beat_req),
    .ARRAY_BEAT_INDEX(beat_idx), .ARRAY_RD_DATA(arr_data), .ARRAY_WR_DATA(arr_wdata),
    .MPR_ENABLED(mpr_en), .MODE_WORD(mode_word), .MODE_UPDATED(mode_upd)
  );

  mpr_ctrl_model ctl (.link_ck(LINK_CK), .cmd(cmd), .bank(bank), .addr(addr), .dq(dq_out), .dq_oe_n(dq_oe_n));

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // kind 0 array, 1 pattern, 2 reserved select
  function automatic logic [7:0] exp_beat(input int kind, input int pos, input logic all);
    logic b;
    b = pos[0];
    if (kind == 0)
      return {5'h13, pos[2:0]};
    if (kind == 2)
      return 8'h00;
    return all ? {8{b}} : {7'h00, b};
  endfunction

  task automatic check_bits(input string what, input logic [18:0] exp, input logic [18:0] got);
    check_count++;
    if (got !== exp)
    begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic check_range(input string what, input int lo, input int hi, input int got);
    check_count++;
    if (got < lo || got > hi)
    begin
      errors++;
      $display("BAD %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask

  task automatic run_read(input logic [13:0] a, input int n, input int start, input int kind);
    int at;
    int t;
    ctl.read(3'(rnd()), a, at);
    for (t = 0; t < 80 && ctl.beats.size() < n; t++)
      @(posedge LINK_CK);
    // long enough for a stray burst at the largest latency used to show up
    repeat (30) @(posedge LINK_CK);
    #1;
    check_range("beat count", n, n, ctl.beats.size());
    if (n > 0)
      check_range("latency", al + cl + 1, al + cl + 2, ctl.first_cyc - at);
    for (t = 0; t < n && t < ctl.beats.size(); t++)
      check_bits("beat", 19'(exp_beat(kind, start + t, all_dq)), 19'(ctl.beats[t]));
  endtask

  task automatic complete_run();
    $display("errors %0d checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial
  begin
    int i;
    int shape;
    logic [13:0] a;
    repeat (20) @(posedge CORE_CLK);
    #1;
    SYS_RST = 1'b0;
    repeat (4) @(posedge LINK_CK);
    #1;
    ctl.mode_set(1'b0, 2'h3);
    check_bits("mode word", {3'h3, 2'h0, 14'h0003}, mode_word);
    check_bits("readout flag", 19'h0, 19'(mpr_en));
    dq_in = 8'(rnd());
    ctl.issue(mpr_pkg::CMD_WRITE, 3'h1, 14'h0040, i);
    repeat (3) @(posedge LINK_CK);
    #1;
    check_bits("array column", 19'h00040, 19'(arr_col));
    check_bits("array bank", 19'h00001, 19'(arr_bank));
    check_bits("array write data", 19'(dq_in), 19'(arr_wdata));
    run_read(14'h1000, 8, 0, 0);
    ctl.mode_set(1'b1, 2'h0);
    check_bits("readout flag", 19'h1, 19'(mpr_en));
    for (i = 0; i < 15; i++)
    begin
      shape = i % 3;
      cl = 5'(5 + rnd() % 7);
      al = (i % 2) ? cl - 5'(1 + rnd() % 2) : 5'h00;
      all_dq = 1'(rnd());
      a = 14'(rnd()) & 14'h2ff8;
      a[12] = (shape == 0);
      a[2] = (shape == 2);
      run_read(a, shape == 0 ? 8 : 4, shape == 2 ? 4 : 0, 1);
    end
    otf = 1'b0;
    fix_chop = 1'b1;
    run_read(14'h1000, 4, 0, 1);
    fix_chop = 1'b0;
    run_read(14'h0000, 8, 0, 1);
    otf = 1'b1;
    dll = 1'b0;
    run_read(14'h1000, 0, 0, 1);
    dll = 1'b1;
    check_bits("mode word held", {3'h3, 2'h0, 14'h0004}, mode_word);
    ctl.issue(mpr_pkg::CMD_WRITE, 3'h2, 14'h0100, shape);
    for (i = 1; i < 4; i++)
    begin
      ctl.mode_set(1'b1, 2'(i));
      run_read(14'h1000, 8, 0, 2);
    end
    ctl.mode_set(1'b1, 2'h0);
    SYS_RST = 1'b1;
    repeat (8) @(posedge CORE_CLK);
    #1;
    SYS_RST = 1'b0;
    check_bits("mode after reset", 19'h0, mode_word);
    check_bits("flag after reset", 19'h0, 19'(mpr_en));
    repeat (4) @(posedge LINK_CK);
    #1;
    run_read(14'h1000, 8, 0, 0);
    check_range("mode updates", 6, 6, upd_count);
    complete_run();
  end

  // twenty-two bursts, each under a microsecond
  initial
  begin
    #200000;
    errors++;
    complete_run();
  end
endmodule // testbench

`default_nettype wire
